// *** include/flash_cmd_regs.vh ***
`ifndef FLASH_CMD_REGS_VH
`define FLASH_CMD_REGS_VH

// opcode values, as taken in after the select line falls
`define SFD_OP_LATCH_SET     8'h06
`define SFD_OP_LATCH_CLR     8'h04
`define SFD_OP_STATUS_WRITE  8'h01
`define SFD_OP_PROGRAM       8'h02
`define SFD_OP_SECTOR_ERASE  8'hD8
`define SFD_OP_BULK_ERASE    8'hC7
`define SFD_OP_READ          8'h03
`define SFD_OP_FAST_READ     8'h0B
`define SFD_OP_STATUS_READ   8'h05
`define SFD_OP_ID_READ_A     8'h9F
`define SFD_OP_ID_READ_B     8'h9E
`define SFD_OP_DPD_ENTER     8'hB9
`define SFD_OP_DPD_RELEASE   8'hAB

// operand byte counts
`define SFD_ADDR_BYTES       4'h3
`define SFD_DUMMY_BYTES      4'h1
`define SFD_STATUS_BYTES     4'h1
`define SFD_PROG_MIN_DATA    4'h1
`define SFD_NO_OPERANDS      4'h0
`define SFD_CNT_MAX          4'hF
`define SFD_ID_MAX_BYTES     5'h14

// output byte sources, shown on out_kind_o
`define SFD_OUT_ARRAY        2'h0
`define SFD_OUT_STATUS       2'h1
`define SFD_OUT_ID           2'h2
`define SFD_OUT_SIGNATURE    2'h3

// widths and buffer depth
`define SFD_ADDR_W           24
`define SFD_DATA_W           8
`define SFD_FIFO_DEPTH       8
`define SFD_FIFO_PTR_W       3

`endif

// *** hw/pin_sync.v ***
`timescale 1ns/1ns
// two-flop synchroniser, one chain per bit
module pin_sync #(
	parameter             WIDTH     = 1,
	parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
	// clock and reset
	input  wire             clk_i,
	input  wire             rst_n_i,
	// pins and synchronised copies
	input  wire [WIDTH-1:0] async_i,
	output wire [WIDTH-1:0] sync_o
);

	genvar g;
	generate
		for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
			reg meta;   // first stage, read only by the second
			reg stable; // second stage, safe to use
			// two stages per bit; nothing taps the first
			always @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					meta   <= RESET_VAL[g];
					stable <= RESET_VAL[g];
				end else begin
					meta   <= async_i[g];
					stable <= meta;
				end
			end
			assign sync_o[g] = stable;
		end
	endgenerate

endmodule // pin_sync

// *** hw/byte_fifo.v ***
`timescale 1ns/1ns
// small synchronous fifo; depth must be a power of two so pointers wrap
module byte_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter PTR_W = 3
) (
	// clock and reset
	input  wire             clk_i,
	input  wire             rst_n_i,
	// drop everything held
	input  wire             flush_i,
	// filling side
	input  wire [WIDTH-1:0] in_data_i,
	input  wire             in_valid_i,
	output wire             in_ready_o,
	// draining side
	output wire [WIDTH-1:0] out_data_o,
	output wire             out_valid_o,
	input  wire             out_ready_i
);

	localparam [PTR_W:0] FULL_COUNT = DEPTH[PTR_W:0];

	reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage, no reset needed
	reg [PTR_W-1:0] wr_ptr;          // next slot to fill
	reg [PTR_W-1:0] rd_ptr;          // oldest entry
	reg [PTR_W:0]   count;           // entries held

	wire push = in_valid_i & in_ready_o;
	wire pop  = out_valid_o & out_ready_i;

	assign in_ready_o  = (count != FULL_COUNT);
	assign out_valid_o = (count != {(PTR_W+1){1'b0}});
	assign out_data_o  = mem[rd_ptr];

	// storage write; a flush only moves pointers
	always @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	// pointers and fill count
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_ptr <= {PTR_W{1'b0}};
			rd_ptr <= {PTR_W{1'b0}};
			count  <= {(PTR_W+1){1'b0}};
		end else if (flush_i) begin
			wr_ptr <= {PTR_W{1'b0}};
			rd_ptr <= {PTR_W{1'b0}};
			count  <= {(PTR_W+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + {{(PTR_W-1){1'b0}}, 1'b1};
			end
			if (pop) begin
				rd_ptr <= rd_ptr + {{(PTR_W-1){1'b0}}, 1'b1};
			end
			if (push & ~pop) begin
				count <= count + {{PTR_W{1'b0}}, 1'b1};
			end else if (pop & ~push) begin
				count <= count - {{PTR_W{1'b0}}, 1'b1};
			end
		end
	end

endmodule // byte_fifo

// *** hw/serial_flash_command_decoder.v ***
`timescale 1ns/1ns
// Behaviour
// - all serial bits travel msb first
// - take input bits on rising shift edges
// - transaction starts with one opcode byte
// - read-type commands shift out data after operands
// - select rise ends reads without error
// - off-boundary select rise discards modifying command
// - ignore array access while cycle busy
// - decode latch set, clear, status write
// - decode program, sector erase, bulk erase
// - decode normal read, three address bytes
// - decode fast read with one dummy byte
// - decode power-down entry and release
// - decode status read and identification read
// - drive output bits on falling edges
// - modifying commands need write latch set
// - clear write latch at reset, completion
`include "flash_cmd_regs.vh"
module serial_flash_command_decoder #(
	parameter FIFO_DEPTH = `SFD_FIFO_DEPTH,
	parameter FIFO_PTR_W = `SFD_FIFO_PTR_W
) (
	// clock and reset
	input  wire                    clk_i,
	input  wire                    rst_n_i,
	// serial pins from the host
	input  wire                    sel_n_i,
	input  wire                    sck_i,
	input  wire                    serial_in_i,
	output reg                     serial_out_o,
	output reg                     serial_out_oe_o,
	// internal engine status
	input  wire                    busy_i,
	input  wire                    op_done_i,
	// output byte fetch
	output reg                     out_req_o,
	output reg  [1:0]              out_kind_o,
	output reg  [`SFD_ADDR_W-1:0]  addr_o,
	input  wire [`SFD_DATA_W-1:0]  out_data_i,
	// program data stream to the page buffer
	output wire [`SFD_DATA_W-1:0]  prog_data_o,
	output wire                    prog_valid_o,
	input  wire                    prog_ready_i,
	output reg                     prog_overrun_o,
	// command launches
	output reg                     prog_go_o,
	output reg                     prog_discard_o,
	output reg                     sector_erase_go_o,
	output reg                     bulk_erase_go_o,
	output reg                     status_write_go_o,
	output reg  [`SFD_DATA_W-1:0]  status_data_o,
	// device state
	output reg                     write_latch_o,
	output reg                     power_down_o
);

	// one-hot decoder states
	localparam [6:0] ST_IDLE     = 7'h01;
	localparam [6:0] ST_OPCODE   = 7'h02;
	localparam [6:0] ST_ADDR     = 7'h04;
	localparam [6:0] ST_DUMMY    = 7'h08;
	localparam [6:0] ST_DATA_IN  = 7'h10;
	localparam [6:0] ST_DATA_OUT = 7'h20;
	localparam [6:0] ST_IGNORE   = 7'h40;

	wire [2:0] pins_s;      // synchronised select, clock, data
	reg        sel_n_q;     // previous select, for edges
	reg        sck_q;       // previous shift clock, for edges
	reg  [6:0] state;       // decoder state
	reg  [2:0] bit_cnt;     // bit position inside current byte
	reg  [3:0] in_cnt;      // operand bytes after the opcode
	reg  [7:0] opcode;      // accepted opcode
	reg  [7:0] rx_shift;    // input shifter
	reg  [7:0] tx_shift;    // output shifter
	reg        tx_blank;    // identification ran past its end
	reg  [4:0] id_cnt;      // identification bytes requested

	wire sel_n_s     = pins_s[2];
	wire sck_s       = pins_s[1];
	wire serial_in_s = pins_s[0];

	// link clock is sampled, so edges are found two cycles late
	wire selected = ~sel_n_s;
	wire sel_fall = sel_n_q & ~sel_n_s;
	wire sel_rise = ~sel_n_q & sel_n_s;
	wire sck_rise = selected & sck_s & ~sck_q;
	wire sck_fall = selected & ~sck_s & sck_q;

	wire [7:0] rx_byte  = {rx_shift[6:0], serial_in_s};
	wire       byte_done = sck_rise & (bit_cnt == 3'h7);
	wire [3:0] in_cnt_inc = (in_cnt == `SFD_CNT_MAX) ? in_cnt : in_cnt + 4'h1;
	wire [7:0] tx_load = tx_blank ? 8'h00 : out_data_i;

	// host keeps the boundary, we only judge it
	wire boundary = (bit_cnt == 3'h0);
	wire commit   = sel_rise & boundary & (state == ST_DATA_IN);

	wire latch_set = commit & (opcode == `SFD_OP_LATCH_SET) & (in_cnt == `SFD_NO_OPERANDS);
	wire latch_clr = commit & (opcode == `SFD_OP_LATCH_CLR) & (in_cnt == `SFD_NO_OPERANDS);
	// completion or latch clear drops it; a set wins
	wire next_write_latch = latch_set | (write_latch_o & ~(op_done_i | latch_clr));

	wire status_ok = commit & write_latch_o & (opcode == `SFD_OP_STATUS_WRITE) &
	                 (in_cnt == `SFD_STATUS_BYTES);
	// program needs address plus at least one byte
	wire prog_ok   = commit & write_latch_o & (opcode == `SFD_OP_PROGRAM) &
	                 (in_cnt >= (`SFD_ADDR_BYTES + `SFD_PROG_MIN_DATA));
	wire erase_ok  = commit & write_latch_o & (opcode == `SFD_OP_SECTOR_ERASE) &
	                 (in_cnt == `SFD_ADDR_BYTES);
	wire bulk_ok   = commit & write_latch_o & (opcode == `SFD_OP_BULK_ERASE) &
	                 (in_cnt == `SFD_NO_OPERANDS);
	wire dpd_enter = commit & (opcode == `SFD_OP_DPD_ENTER) & (in_cnt == `SFD_NO_OPERANDS);
	// release happens however the read is cut
	wire dpd_leave = sel_rise & (state == ST_DATA_OUT) & (opcode == `SFD_OP_DPD_RELEASE);

	// a bad ending drops buffered program bytes
	wire prog_drop = sel_rise & (opcode == `SFD_OP_PROGRAM) & ~prog_ok &
	                 ((state == ST_ADDR) | (state == ST_DATA_IN));

	// program bytes enter the buffer as they complete
	wire fifo_push  = byte_done & (state == ST_DATA_IN) & (opcode == `SFD_OP_PROGRAM);
	wire fifo_ready;

	// select, clock and data all cross with the same delay
	pin_sync #(
		.WIDTH     (3),
		.RESET_VAL (3'h4)
	) u_pin_sync (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.async_i ({sel_n_i, sck_i, serial_in_i}),
		.sync_o  (pins_s)
	);

	// the serial host cannot be stalled, so a full buffer is flagged
	byte_fifo #(
		.WIDTH (`SFD_DATA_W),
		.DEPTH (FIFO_DEPTH),
		.PTR_W (FIFO_PTR_W)
	) u_prog_fifo (
		.clk_i       (clk_i),
		.rst_n_i     (rst_n_i),
		.flush_i     (prog_drop),
		.in_data_i   (rx_byte),
		.in_valid_i  (fifo_push),
		.in_ready_o  (fifo_ready),
		.out_data_o  (prog_data_o),
		.out_valid_o (prog_valid_o),
		.out_ready_i (prog_ready_i)
	);

	// edge history of the synchronised pins
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sel_n_q <= 1'b1;
			sck_q   <= 1'b0;
		end else begin
			sel_n_q <= sel_n_s;
			sck_q   <= sck_s;
		end
	end


	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			write_latch_o <= 1'b0;
		end else begin
			write_latch_o <= next_write_latch;
		end
	end

	// command launches and power-down mode
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prog_go_o         <= 1'b0;
			prog_discard_o    <= 1'b0;
			sector_erase_go_o <= 1'b0;
			bulk_erase_go_o   <= 1'b0;
			status_write_go_o <= 1'b0;
			power_down_o      <= 1'b0;
		end else begin
			prog_go_o         <= prog_ok;
			prog_discard_o    <= prog_drop;
			sector_erase_go_o <= erase_ok;
			bulk_erase_go_o   <= bulk_ok;
			status_write_go_o <= status_ok;
			if (dpd_enter) begin
				power_down_o <= 1'b1;
			end else if (dpd_leave) begin
				power_down_o <= 1'b0;
			end
		end
	end

	// overrun flag holds until the next select fall opens a frame
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prog_overrun_o <= 1'b0;
		end else if (fifo_push & ~fifo_ready) begin
			prog_overrun_o <= 1'b1;
		end else if (sel_fall) begin
			prog_overrun_o <= 1'b0;
		end
	end

	// main framing, decode and shifting
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state           <= ST_IDLE;
			bit_cnt         <= 3'h0;
			in_cnt          <= 4'h0;
			opcode          <= 8'h00;
			rx_shift        <= 8'h00;
			tx_shift        <= 8'h00;
			tx_blank        <= 1'b0;
			id_cnt          <= 5'h00;
			out_req_o       <= 1'b0;
			out_kind_o      <= `SFD_OUT_ARRAY;
			addr_o          <= {`SFD_ADDR_W{1'b0}};
			status_data_o   <= 8'h00;
			serial_out_o    <= 1'b0;
			serial_out_oe_o <= 1'b0;
		end else begin
			out_req_o <= 1'b0;
			if (sel_fall) begin
				// every frame opens with an opcode
				state    <= ST_OPCODE;
				bit_cnt  <= 3'h0;
				in_cnt   <= 4'h0;
				tx_blank <= 1'b0;
				id_cnt   <= 5'h00;
			end else if (sel_rise) begin
				// counters back to a fresh byte
				state           <= ST_IDLE;
				bit_cnt         <= 3'h0;
				in_cnt          <= 4'h0;
				serial_out_oe_o <= 1'b0;
			end else if (sck_rise) begin
				bit_cnt  <= bit_cnt + 3'h1;
				rx_shift <= rx_byte;
				if (bit_cnt == 3'h7) begin
					case (state)
						ST_OPCODE: begin
							opcode <= rx_byte;
							if ((busy_i & (rx_byte != `SFD_OP_STATUS_READ)) |
							    (power_down_o & (rx_byte != `SFD_OP_DPD_RELEASE))) begin
								state <= ST_IGNORE;
							end else begin
								case (rx_byte)
									// operands collected, judged at select rise
									`SFD_OP_LATCH_SET, `SFD_OP_LATCH_CLR,
									`SFD_OP_STATUS_WRITE, `SFD_OP_BULK_ERASE,
									`SFD_OP_DPD_ENTER: begin
										state <= ST_DATA_IN;
									end
									`SFD_OP_READ, `SFD_OP_FAST_READ,
									`SFD_OP_PROGRAM, `SFD_OP_SECTOR_ERASE: begin
										state <= ST_ADDR;
									end
									`SFD_OP_STATUS_READ: begin
										state      <= ST_DATA_OUT;
										out_kind_o <= `SFD_OUT_STATUS;
										out_req_o  <= 1'b1;
									end
									`SFD_OP_ID_READ_A, `SFD_OP_ID_READ_B: begin
										state      <= ST_DATA_OUT;
										out_kind_o <= `SFD_OUT_ID;
										out_req_o  <= 1'b1;
										id_cnt     <= 5'h01;
									end
									`SFD_OP_DPD_RELEASE: begin
										state      <= ST_DATA_OUT;
										out_kind_o <= `SFD_OUT_SIGNATURE;
										out_req_o  <= 1'b1;
									end
									default: begin
										state <= ST_IGNORE;
									end
								endcase
							end
						end
						ST_ADDR: begin
							addr_o <= {addr_o[15:0], rx_byte};
							in_cnt <= in_cnt_inc;
							if (in_cnt_inc == `SFD_ADDR_BYTES) begin
								if (opcode == `SFD_OP_READ) begin
									state      <= ST_DATA_OUT;
									out_kind_o <= `SFD_OUT_ARRAY;
									out_req_o  <= 1'b1;
								end else if (opcode == `SFD_OP_FAST_READ) begin
									state <= ST_DUMMY;
								end else begin
									state <= ST_DATA_IN;
								end
							end
						end
						ST_DUMMY: begin
							in_cnt <= in_cnt_inc;
							if (in_cnt_inc == (`SFD_ADDR_BYTES + `SFD_DUMMY_BYTES)) begin
								state      <= ST_DATA_OUT;
								out_kind_o <= `SFD_OUT_ARRAY;
								out_req_o  <= 1'b1;
							end
						end
						ST_DATA_IN: begin
							in_cnt <= in_cnt_inc;
							// first data byte is the new status value
							if ((opcode == `SFD_OP_STATUS_WRITE) &&
							    (in_cnt == `SFD_NO_OPERANDS)) begin
								status_data_o <= rx_byte;
							end
						end
						ST_DATA_OUT: begin
							// fetch the next byte at each boundary
							out_req_o <= 1'b1;
							if (out_kind_o == `SFD_OUT_ARRAY) begin
								addr_o <= addr_o + {{(`SFD_ADDR_W-1){1'b0}}, 1'b1};
							end
							// identification stops after its last byte
							if (out_kind_o == `SFD_OUT_ID) begin
								if (id_cnt == `SFD_ID_MAX_BYTES) begin
									tx_blank <= 1'b1;
								end else begin
									id_cnt <= id_cnt + 5'h01;
								end
							end
						end
						default: begin
							// idle or ignoring: bits are swallowed
						end
					endcase
				end
			end else if (sck_fall && (state == ST_DATA_OUT)) begin
				serial_out_oe_o <= 1'b1;
				if (boundary) begin
					serial_out_o <= tx_load[7];
					tx_shift     <= {tx_load[6:0], 1'b0};
				end else begin
					serial_out_o <= tx_shift[7];
					tx_shift     <= {tx_shift[6:0], 1'b0};
				end
			end
		end
	end

endmodule // serial_flash_command_decoder

// *** bench/serial_flash_command_decoder_properties.sv ***
`timescale 1ns/1ns
// port-level timing checks for the command decoder
module sfd_checker (
	// clock and reset
	input wire        clk_i,
	input wire        rst_n_i,
	// serial pins
	input wire        sel_n_i,
	input wire        sck_i,
	input wire        serial_out_o,
	input wire        serial_out_oe_o,
	// engine side
	input wire        busy_i,
	input wire        op_done_i,
	input wire        out_req_o,
	input wire [1:0]  out_kind_o,
	input wire [23:0] addr_o,
	input wire        prog_valid_o,
	// launches and state
	input wire        prog_go_o,
	input wire        prog_discard_o,
	input wire        sector_erase_go_o,
	input wire        bulk_erase_go_o,
	input wire        status_write_go_o,
	input wire        write_latch_o,
	input wire        power_down_o
);
	// any launch; the pulses never overlap in practice
	wire go = prog_go_o | sector_erase_go_o | bulk_erase_go_o | status_write_go_o;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	property p_oe_idle; sel_n_i [*6] |-> !serial_out_oe_o; endproperty
	a_oe_idle: assert property (p_oe_idle) else $error("drive while deselected");
	property p_oe_rise; $rose(serial_out_oe_o) |-> !sel_n_i && !sck_i; endproperty
	a_oe_rise: assert property (p_oe_rise) else $error("drive start off a fall");
	property p_sout; $changed(serial_out_o) && serial_out_oe_o |-> !sck_i && !$past(sck_i, 3);
	endproperty
	a_sout: assert property (p_sout) else $error("output bit moved off a fall");
	property p_go_sel; go |-> $past(sel_n_i, 3); endproperty
	a_go_sel: assert property (p_go_sel) else $error("launch before select rise");
	property p_go_latch; go |-> $past(write_latch_o); endproperty
	a_go_latch: assert property (p_go_latch) else $error("launch with latch clear");
	property p_go_busy; go |-> !$past(busy_i, 4); endproperty
	a_go_busy: assert property (p_go_busy) else $error("launch while busy");
	property p_latch_sel; $rose(write_latch_o) |-> $past(sel_n_i, 3); endproperty
	a_latch_sel: assert property (p_latch_sel) else $error("latch set in frame");
	property p_latch_done; sel_n_i [*6] ##0 op_done_i |=> !write_latch_o; endproperty
	a_latch_done: assert property (p_latch_done) else $error("latch kept");
	property p_pd_sel; $changed(power_down_o) |-> $past(sel_n_i, 3); endproperty
	a_pd_sel: assert property (p_pd_sel) else $error("power mode moved in frame");
	property p_addr_inc;
		out_req_o && serial_out_oe_o && out_kind_o == 2'h0 |-> addr_o == $past(addr_o) + 24'h1;
	endproperty
	a_addr_inc: assert property (p_addr_inc) else $error("address not stepped");
	property p_discard; prog_discard_o |-> ##[1:2] !prog_valid_o; endproperty
	a_discard: assert property (p_discard) else $error("buffer kept on discard");
	c_status_write: cover property (status_write_go_o);
	c_discard: cover property (prog_discard_o);
	c_read_out: cover property ($rose(serial_out_oe_o));
endmodule // sfd_checker

bind serial_flash_command_decoder sfd_checker chk (.*);

// *** bench/spi_host_model.sv ***
`timescale 1ns/1ns
// serial host, mode 0; its clock stands still between frames
module spi_host_model (
	// clock
	input  wire       clk_i,
	// serial pins
	output reg        sel_n_o,
	output reg        sck_o,
	output reg        sdi_o,
	input  wire       sdo_i,
	// byte read back
	output reg  [7:0] rx_byte_o,
	output reg        rx_done_o
);
	initial begin
		sel_n_o = 1'b1;
		sck_o = 1'b0;
		sdi_o = 1'b0;
		rx_byte_o = 8'h00;
		rx_done_o = 1'b0;
	end
	// wait n clocks, then step just off the edge
	task tick(input integer n);
		begin
			repeat (n) @(posedge clk_i);
			#1;
		end
	endtask
	task open_frame;
		begin
			sel_n_o = 1'b0;
			tick(5);
		end
	endtask
	task shift(input [7:0] tx, input integer nb, input rd);
		integer i;
		begin
			for (i = 0; i < nb; i = i + 1) begin
				sdi_o = tx[7-i];
				tick(5);
				rx_byte_o[7-i] = sdo_i;
				sck_o = 1'b1;
				tick(5);
				sck_o = 1'b0;
			end
			rx_done_o = rd;
			tick(1);
			rx_done_o = 1'b0;
		end
	endtask
	// released data line shows no stale bit; gap exceeds detection delay
	task close_frame;
		begin
			sel_n_o = 1'b1;
			sdi_o = ~sdi_o;
			tick(6);
		end
	endtask
endmodule // spi_host_model

// *** bench/test_serial_flash_command_decoder.sv ***
`timescale 1ns/1ns
`include "flash_cmd_regs.vh"
module test_serial_flash_command_decoder;
	reg         clk_i;
	reg         rst_n_i;
	reg         busy_i;
	reg         op_done_i;
	reg  [7:0]  out_data_i;
	reg         prog_ready_i;
	reg         stall;
	wire        sel_n_i, sck_i, serial_in_i, serial_out_o, serial_out_oe_o;
	wire        out_req_o, prog_valid_o, prog_overrun_o, rx_done;
	wire [1:0]  out_kind_o;
	wire [23:0] addr_o;
	wire [7:0]  prog_data_o, status_data_o, rx_byte;
	wire        prog_go_o, prog_discard_o, sector_erase_go_o, bulk_erase_go_o;
	wire        status_write_go_o, write_latch_o, power_down_o;
	reg  [31:0] seed, a, b;
	integer     i, k, cycles, reqs, mismatches, comparisons;
	reg  [7:0]  opq[$], exp_rd[$], exp_pg[$];
	reg  [12:0] exp_ev[$];
	// launch code seen this clock
	wire [12:0] ev_now = {prog_go_o, prog_discard_o, sector_erase_go_o, bulk_erase_go_o,
		status_write_go_o, status_write_go_o ? status_data_o : 8'h00};

	serial_flash_command_decoder uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .sel_n_i(sel_n_i),
		.sck_i(sck_i), .serial_in_i(serial_in_i), .serial_out_o(serial_out_o),
		.serial_out_oe_o(serial_out_oe_o), .busy_i(busy_i), .op_done_i(op_done_i),
		.out_req_o(out_req_o), .out_kind_o(out_kind_o), .addr_o(addr_o),
		.out_data_i(out_data_i), .prog_data_o(prog_data_o), .prog_valid_o(prog_valid_o),
		.prog_ready_i(prog_ready_i), .prog_overrun_o(prog_overrun_o), .prog_go_o(prog_go_o),
		.prog_discard_o(prog_discard_o), .sector_erase_go_o(sector_erase_go_o),
		.bulk_erase_go_o(bulk_erase_go_o), .status_write_go_o(status_write_go_o),
		.status_data_o(status_data_o), .write_latch_o(write_latch_o),
		.power_down_o(power_down_o));
	spi_host_model host (.clk_i(clk_i), .sel_n_o(sel_n_i), .sck_o(sck_i), .sdi_o(serial_in_i),
		.sdo_i(serial_out_oe_o ? serial_out_o : ~serial_out_o), .rx_byte_o(rx_byte),
		.rx_done_o(rx_done));

	// engine byte pattern: array bytes follow the address, others the source
	function [7:0] f(input [23:0] ad, input [1:0] kd);
		f = (kd == 2'h0) ? (ad[7:0] ^ 8'hA5) : {kd, 6'h15};
	endfunction
	task check(input [15:0] seen, input [15:0] exp);
		begin
			comparisons = comparisons + 1;
			if (seen !== exp) begin
				mismatches = mismatches + 1;
				$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task finish_test;
		begin
			if (mismatches == 0 && comparisons > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	task addr3(input [23:0] ad);
		begin
			opq.push_back(ad[23:16]);
			opq.push_back(ad[15:8]);
			opq.push_back(ad[7:0]);
		end
	endtask
	// opcode, operands, reads, then nt stray bits
	task cmd(input [7:0] op, input integer nrd, input integer nt);
		begin
			host.open_frame;
			host.shift(op, 8, 1'b0);
			while (opq.size() > 0)
				host.shift(opq.pop_front(), 8, 1'b0);
			for (i = 0; i < nrd; i = i + 1)
				host.shift(8'h00, 8, 1'b1);
			if (nt > 0)
				host.shift(8'hFF, nt, 1'b0);
			host.close_frame;
		end
	endtask
	// engine finishes its cycle
	task done;
		begin
			op_done_i = 1'b1;
			host.tick(1);
			op_done_i = 1'b0;
			host.tick(1);
			check(write_latch_o, 1'b0);
		end
	endtask

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	// engine model: byte one clock after each request, random stalls
	always @(posedge clk_i) begin
		if (out_req_o)
			out_data_i <= #1 f(addr_o, out_kind_o);
		prog_ready_i <= #1 ~stall & ($random(seed) > 0);
	end
	// watcher: oldest note against each result, plus the run limit
	always @(posedge clk_i) begin
		cycles = cycles + 1;
		if (out_req_o)
			reqs = reqs + 1;
		if ((|ev_now) !== 1'b0)
			check(ev_now, exp_ev.pop_front());
		if (rx_done)
			check(rx_byte, exp_rd.pop_front());
		if ((prog_valid_o & prog_ready_i) !== 1'b0)
			check(prog_data_o, exp_pg.pop_front());
		if (cycles == 30000) begin
			mismatches = mismatches + 1;
			finish_test;
		end
	end

	initial begin
		seed = 32'h2D7048EC;
		{rst_n_i, busy_i, op_done_i, stall, prog_ready_i} = 5'h00;
		{out_data_i, cycles, reqs, mismatches, comparisons} = 0;
		repeat (6) @(posedge clk_i);
		#1 rst_n_i = 1'b1;
		host.tick(3);
		// normal then fast read, select raised mid-byte
		for (k = 0; k < 2; k = k + 1) begin
			a = $random(seed);
			addr3(a[23:0]);
			if (k == 1)
				opq.push_back(8'h00);
			for (b = 0; b < 3; b = b + 1)
				exp_rd.push_back(f(a[23:0] + b[23:0], 2'h0));
			cmd(k ? `SFD_OP_FAST_READ : `SFD_OP_READ, 3, 3);
		end
		// both identification codes
		for (k = 0; k < 4; k = k + 1)
			exp_rd.push_back(f(24'h0, 2'h2));
		cmd(`SFD_OP_ID_READ_A, 2, 0);
		cmd(`SFD_OP_ID_READ_B, 2, 5);
		// busy: status still answers, array read and erase ignored
		cmd(`SFD_OP_LATCH_SET, 0, 0);
		busy_i = 1'b1;
		exp_rd.push_back(f(24'h0, 2'h1));
		exp_rd.push_back(f(24'h0, 2'h1));
		cmd(`SFD_OP_STATUS_READ, 2, 4);
		k = reqs;
		addr3(a[23:0]);
		cmd(`SFD_OP_READ, 0, 8);
		check(reqs, k);
		cmd(`SFD_OP_BULK_ERASE, 0, 0);
		busy_i = 1'b0;
		// latch set, then each modifying launch
		for (k = 0; k < 4; k = k + 1) begin
			cmd(`SFD_OP_LATCH_SET, 0, 0);
			check(write_latch_o, 1'b1);
			if (k == 0 || k == 2)
				addr3(a[23:0]);
			b = $random(seed);
			if (k >= 2)
				opq.push_back(b[7:0]);
			if (k == 2)
				exp_pg.push_back(b[7:0]);
			exp_ev.push_back(k == 0 ? 13'h0400 : k == 1 ? 13'h0200 :
				k == 2 ? 13'h1000 : {5'h01, b[7:0]});
			cmd(k == 0 ? `SFD_OP_SECTOR_ERASE : k == 1 ? `SFD_OP_BULK_ERASE :
				k == 2 ? `SFD_OP_PROGRAM : `SFD_OP_STATUS_WRITE, 0, 0);
			done;
		end
		// refused: latch cleared, latch never set, off boundary, unknown
		cmd(`SFD_OP_LATCH_SET, 0, 0);
		cmd(`SFD_OP_LATCH_CLR, 0, 0);
		check(write_latch_o, 1'b0);
		cmd(`SFD_OP_BULK_ERASE, 0, 0);
		addr3(a[23:0]);
		cmd(`SFD_OP_SECTOR_ERASE, 0, 0);
		cmd(`SFD_OP_LATCH_SET, 0, 0);
		cmd(`SFD_OP_BULK_ERASE, 0, 3);
		cmd(8'hFF, 0, 16);
		check(write_latch_o, 1'b1);
		// stalled program overfills the buffer, then ends off boundary
		stall = 1'b1;
		addr3(a[23:0]);
		for (k = 0; k < 9; k = k + 1)
			opq.push_back(k[7:0]);
		exp_ev.push_back(13'h0800);
		cmd(`SFD_OP_PROGRAM, 0, 4);
		check(prog_overrun_o, 1'b1);
		check(prog_valid_o, 1'b0);
		stall = 1'b0;
		// power-down ignores reads until release
		cmd(`SFD_OP_DPD_ENTER, 0, 0);
		check(power_down_o, 1'b1);
		k = reqs;
		addr3(a[23:0]);
		cmd(`SFD_OP_READ, 0, 8);
		check(reqs, k);
		exp_rd.push_back(f(24'h0, 2'h3));
		cmd(`SFD_OP_DPD_RELEASE, 1, 2);
		check(power_down_o, 1'b0);
		// mid-run reset clears the latch as at power-up
		check(write_latch_o, 1'b1);
		rst_n_i = 1'b0;
		host.tick(2);
		rst_n_i = 1'b1;
		host.tick(3);
		check(write_latch_o, 1'b0);
		check(exp_ev.size() + exp_rd.size() + exp_pg.size(), 0);
		finish_test;
	end
endmodule // test_serial_flash_command_decoder
